// file: hw/tcf_defines.vh
// Constants of the timer carry flag unit
// Operation
// RL1: Intervals divide the 4.5 MHz system clock
// RL2: Select bits 1:0 of register 09H
// RL3: Selected pulse rising edge sets carry
// RL4: Carry shown as bit 0 of 17H
// RL5: Flag read copies to window, then clears
// RL6: Power-on blocks setting until first read; code lets the restart sync set the flag while locked
// RL7: Chip-enable restart waits for next set
// RL8: Flag zero after power-on, one after restart
// RL9: Writes to the flag do nothing
// RL10: Carry and interrupt intervals set separately
// RL11: Software polls faster than carry period
// RL12: Pulses 1, 5, 100, 250 ms encoded
// RL13: Read beats restart; restart waits once more
// RL14: Selection change sets flag if pulse rises
// RL15: Select code 01 picks 250 ms
// RL16: Edge during read keeps flip-flop set
`ifndef TCF_DEFINES_VH
`define TCF_DEFINES_VH

// Register file addresses
`define TCF_ADDR_W          7
`define TCF_ADDR_MODE       7'h09
`define TCF_ADDR_JUDGE      7'h17

// Field positions in the interval select and flag registers
`define TCF_CARRY_SEL_LSB   0
`define TCF_TINT_SEL_LSB    2
`define TCF_CARRY_FLAG_BIT  0

// Reset values
`define TCF_MODE_RST        4'h0
`define TCF_WIN_RST         4'h0

// Carry select encodings
`define TCF_SEL_100MS       2'h0
`define TCF_SEL_250MS       2'h1
`define TCF_SEL_5MS         2'h2
`define TCF_SEL_1MS         2'h3

// System clock rate and carry periods
`define TCF_SYS_CLK_KHZ     4500
`define TCF_PER_1MS_US      1000
`define TCF_PER_5MS_US      5000
`define TCF_PER_100MS_US    100000
`define TCF_PER_250MS_US    250000

// Half periods in system clock ticks: kHz * us / 2000, sized to the counter
`define TCF_HALF_1MS        20'h008ca
`define TCF_HALF_5MS        20'h02bf2
`define TCF_HALF_100MS      20'h36ee8
`define TCF_HALF_250MS      20'h89544
`define TCF_CNT_W           20

`endif

// file: hw/tcf_pulse_div.v
// Divider producing the four carry setting pulses
`timescale 1ns/1ps
`default_nettype none

module tcf_pulse_div
#(
   parameter [79:0] HALVES = 80'h0
)
(
   // Clock and reset
   input  wire        clock,
   input  wire        rst_n,
   // System clock tick
   input  wire        sys_tick,
   // Square pulses: 1 ms, 5 ms, 100 ms, 250 ms
   output wire [3:0]  pulse
);

   //----------------------------------------
   // One half-period counter per pulse
   //----------------------------------------
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : g_chan
         wire [19:0] half_w = HALVES[i*20 +: 20];
         reg  [19:0] cnt_q;
         reg         pulse_q;

         // One flop per channel, so each bit has one driver
         assign pulse[i] = pulse_q;

         // RL1 divide system clock
         always @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               cnt_q   <= 20'h0;
               pulse_q <= 1'b0;
            end
            else if (sys_tick)
            begin
               if (cnt_q == half_w - 20'h1)
               begin
                  cnt_q   <= 20'h0;
                  pulse_q <= ~pulse_q;
               end
               else
               begin
                  cnt_q <= cnt_q + 20'h1;
               end
            end
         end
      end
   endgenerate

endmodule // tcf_pulse_div

`default_nettype wire

// file: hw/tcf_timer_carry.v
// Timer carry flag unit: interval select, carry flag, restart sync
`timescale 1ns/1ps
`default_nettype none
`include "tcf_defines.vh"

module tcf_timer_carry
#(
   parameter [19:0] HALF_1MS   = `TCF_HALF_1MS,
   parameter [19:0] HALF_5MS   = `TCF_HALF_5MS,
   parameter [19:0] HALF_100MS = `TCF_HALF_100MS,
   parameter [19:0] HALF_250MS = `TCF_HALF_250MS
)
(
   // Clock and power-on reset
   input  wire                   clock,
   input  wire                   rst_n,
   // System clock tick, one per 4.5 MHz period
   input  wire                   sys_tick,
   // Register file access
   input  wire [`TCF_ADDR_W-1:0] rf_addr,
   input  wire                   register_file_read_op,
   input  wire                   register_file_write_op,
   input  wire [3:0]             rf_wdata,
   output wire [3:0]             rf_rdata,
   // Chip-enable pin and restart request
   input  wire                   ce_pin,
   output wire                   ce_restart,
   // State for neighbouring blocks
   output wire                   carry_elapsed_flag,
   output wire [1:0]             timer_int_sel
);

   //----------------------------------------
   // Declarations
   //----------------------------------------
   wire [3:0] pulse;
   reg  [3:0] mode_q;
   reg  [3:0] mode_d;
   reg  [3:0] win_q;
   reg  [3:0] win_d;
   reg        flag_q;
   reg        flag_d;
   reg        lock_q;
   reg        lock_d;
   reg        sel_prev_q;
   reg        ce_prev_q;
   reg        pend_q;
   reg        pend_d;
   reg        restart_q;
   reg        sel_pulse;
   wire [1:0] carry_sel;
   wire       hit_mode;
   wire       hit_judge;
   wire       rd_flag;
   wire       rise;
   wire       ce_rise;
   wire       fire;

   //----------------------------------------
   // Pulse divider
   //----------------------------------------
   // RL12 pulse periods
   tcf_pulse_div
   #(
      .HALVES ({HALF_250MS, HALF_100MS, HALF_5MS, HALF_1MS})
   )
   u_div
   (
      .clock    (clock),
      .rst_n    (rst_n),
      .sys_tick (sys_tick),
      .pulse    (pulse)
   );

   //----------------------------------------
   // Address decode
   //----------------------------------------
   assign hit_mode  = (rf_addr == `TCF_ADDR_MODE);
   assign hit_judge = (rf_addr == `TCF_ADDR_JUDGE);
   assign rd_flag   = register_file_read_op & hit_judge;

   // Field views of the select register
   assign carry_sel     = mode_q[`TCF_CARRY_SEL_LSB +: 2];
   assign timer_int_sel = mode_q[`TCF_TINT_SEL_LSB +: 2];

   //----------------------------------------
   // Carry pulse selector
   //----------------------------------------
   // RL2 low select bits
   always @*
   begin
      case (carry_sel)
         `TCF_SEL_100MS: sel_pulse = pulse[2];
         // RL15 lower bit only
         `TCF_SEL_250MS: sel_pulse = pulse[3];
         `TCF_SEL_5MS:   sel_pulse = pulse[1];
         `TCF_SEL_1MS:   sel_pulse = pulse[0];
         default:        sel_pulse = pulse[2];
      endcase
   end

   // RL14 compare across selection change
   assign rise = sel_pulse & ~sel_prev_q;

   // Chip-enable rising edge
   assign ce_rise = ce_pin & ~ce_prev_q;

   // Sync event ignores the lock, so restart works straight after power-on
   // RL7 restart on next set moment
   // RL13 flag read postpones restart
   assign fire = pend_q & rise & ~rd_flag;

   //----------------------------------------
   // Interval select register
   //----------------------------------------
   // RL10 both fields written together
   always @*
   begin
      mode_d = mode_q;
      if (register_file_write_op & hit_mode)
      begin
         mode_d = rf_wdata;
      end
   end

   //----------------------------------------
   // Window register
   //----------------------------------------
   // RL5 copy value before clearing
   always @*
   begin
      win_d = win_q;
      if (register_file_read_op)
      begin
         if (hit_mode)
         begin
            win_d = mode_q;
         end
         else if (hit_judge)
         begin
            // RL4 flag in bit 0
            win_d = {3'h0, flag_q};
         end
         else
         begin
            win_d = 4'h0; // Unmapped address
         end
      end
   end

   //----------------------------------------
   // Carry flip-flop
   //----------------------------------------
   always @*
   begin
      flag_d = flag_q;
      if (rd_flag)
      begin
         // RL16 edge wins over clear
         flag_d = rise & ~lock_q;
      end
      else if (fire)
      begin
         // RL8 restart leaves flag set
         flag_d = 1'b1;
      end
      else if (rise & ~lock_q)
      begin
         // RL3 set on rising edge
         flag_d = 1'b1;
      end
   end
   // RL9 writes never reach the flag

   //----------------------------------------
   // Power-on lock-out
   //----------------------------------------
   // RL6 released by first flag read
   always @*
   begin
      lock_d = lock_q;
      if (rd_flag)
      begin
         lock_d = 1'b0;
      end
   end

   //----------------------------------------
   // Restart pending request
   //----------------------------------------
   always @*
   begin
      pend_d = pend_q;
      if (ce_rise)
      begin
         pend_d = 1'b1;
      end
      else if (fire)
      begin
         pend_d = 1'b0;
      end
   end

   //----------------------------------------
   // State registers
   //----------------------------------------
   // Interval select register
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= `TCF_MODE_RST;
      end
      else
      begin
         mode_q <= mode_d;
      end
   end

   // Window register
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         win_q <= `TCF_WIN_RST;
      end
      else
      begin
         win_q <= win_d;
      end
   end

   // Carry flip-flop
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // RL8 zero after power-on
         flag_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

   // Power-on lock-out
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // RL6 armed at power-on
         lock_q <= 1'b1;
      end
      else
      begin
         lock_q <= lock_d;
      end
   end

   // Edge samples; reset low like the pulses, so no false edge
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_prev_q <= 1'b0;
         ce_prev_q  <= 1'b0;
      end
      else
      begin
         sel_prev_q <= sel_pulse;
         ce_prev_q  <= ce_pin;
      end
   end

   // Restart pending request
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_q <= 1'b0;
      end
      else
      begin
         pend_q <= pend_d;
      end
   end

   // One-cycle restart pulse
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         restart_q <= 1'b0;
      end
      else
      begin
         restart_q <= fire;
      end
   end

   //----------------------------------------
   // Outputs
   //----------------------------------------
   assign rf_rdata           = win_q;
   assign ce_restart         = restart_q;
   assign carry_elapsed_flag = flag_q;

endmodule // tcf_timer_carry

`default_nettype wire

// file: dv/tcf_timer_carry_props.sv
// Checker of the timer carry flag unit
`timescale 1ns/1ps
`default_nettype none
`include "tcf_defines.vh"
module tcf_timer_carry_props
#(parameter [19:0] HALF_1MS=2, HALF_5MS=4, HALF_100MS=6, HALF_250MS=8)
(
   // Watched ports
   input wire logic       clock, rst_n, sys_tick, ce_pin, ce_restart,
   input wire logic       register_file_read_op, register_file_write_op,
   input wire logic [6:0] rf_addr,
   input wire logic [3:0] rf_wdata, rf_rdata,
   input wire logic       carry_elapsed_flag,
   input wire logic [1:0] timer_int_sel
);
   // ----------------
   // Properties
   // ----------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire rd_j = register_file_read_op && rf_addr == `TCF_ADDR_JUDGE;
   wire wr_m = register_file_write_op && rf_addr == `TCF_ADDR_MODE;
   wire unm = register_file_read_op && rf_addr != `TCF_ADDR_MODE
      && rf_addr != `TCF_ADDR_JUDGE;
   AST_RD_COPY: assert property (rd_j |=> rf_rdata == {3'h0, $past(carry_elapsed_flag)})
      else $error("flag read wrong");
   AST_WIN_HOLD: assert property (!register_file_read_op |=> $stable(rf_rdata))
      else $error("window changed");
   AST_UNMAP: assert property (unm |=> rf_rdata == 4'h0)
      else $error("unmapped read");
   AST_INT_SEL: assert property (wr_m |=> timer_int_sel == $past(rf_wdata[3:2]))
      else $error("int select");
   AST_INT_HOLD: assert property (!wr_m |=> $stable(timer_int_sel))
      else $error("int select moved");
   AST_FLAG_HOLD: assert property (carry_elapsed_flag && !rd_j |=> carry_elapsed_flag)
      else $error("flag lost");
   AST_CE_FLAG: assert property (ce_restart |-> carry_elapsed_flag)
      else $error("restart without flag");
   AST_CE_ONE: assert property (ce_restart |=> !ce_restart)
      else $error("restart too long");
   AST_CE_READ: assert property (ce_restart |-> !$past(rd_j))
      else $error("restart beat read");
   C_CE: cover property (ce_restart);
   C_RD: cover property (rd_j && carry_elapsed_flag);
   C_WR: cover property (wr_m);
endmodule // tcf_timer_carry_props
bind tcf_timer_carry tcf_timer_carry_props #(.HALF_1MS(HALF_1MS), .HALF_5MS(HALF_5MS),
   .HALF_100MS(HALF_100MS), .HALF_250MS(HALF_250MS)) u_props (.clock(clock),
   .rst_n(rst_n), .sys_tick(sys_tick), .ce_pin(ce_pin), .ce_restart(ce_restart),
   .register_file_read_op(register_file_read_op), .rf_addr(rf_addr),
   .register_file_write_op(register_file_write_op), .rf_wdata(rf_wdata),
   .rf_rdata(rf_rdata), .carry_elapsed_flag(carry_elapsed_flag),
   .timer_int_sel(timer_int_sel));
`default_nettype wire

// file: dv/tcf_timer_carry_tb_top.sv
// Testbench of the timer carry flag unit
`timescale 1ns/1ps
`default_nettype none
`include "tcf_defines.vh"
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin failures++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tcf_timer_carry_tb_top;
   // ----------------
   // Signals
   // ----------------
   logic clock = 0, rst_n = 0, sys_tick = 1, rd = 0, wr = 0, ce_pin = 0;
   logic [6:0] rf_addr = 7'h00;
   logic [3:0] rf_wdata = 4'h0, d;
   wire [3:0]  rf_rdata;
   wire        ce_restart, flag;
   wire [1:0]  int_sel;
   int failures = 0, cmp_count = 0, cyc = 0, n;
   int hv[4] = '{6, 8, 4, 2};
   always #2 clock = ~clock;
   always @(negedge clock) sys_tick <= ~sys_tick;
   tcf_timer_carry #(.HALF_1MS(20'd2), .HALF_5MS(20'd4), .HALF_100MS(20'd6),
      .HALF_250MS(20'd8)) u_tcf_timer_carry (.clock(clock), .rst_n(rst_n),
      .sys_tick(sys_tick), .rf_addr(rf_addr), .register_file_read_op(rd),
      .register_file_write_op(wr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata),
      .ce_pin(ce_pin), .ce_restart(ce_restart), .carry_elapsed_flag(flag),
      .timer_int_sel(int_sel));
   // ----------------
   // Tasks
   // ----------------
   task rd_reg(input [6:0] a);
      @(negedge clock); rf_addr = a; rd = 1;
      @(negedge clock); rd = 0; d = rf_rdata;
   endtask
   task wr_reg(input [6:0] a, input [3:0] v);
      @(negedge clock); rf_addr = a; rf_wdata = v; wr = 1;
      @(negedge clock); wr = 0;
   endtask
   // poll every cycle, far faster than period
   task wait_flag;
      n = 0;
      while (flag !== 1'b1 && n < 60) begin @(negedge clock); n++; end
   endtask
   task t_lock;
      repeat (40) @(negedge clock);
      `CHK(flag, 1'b0)
      rd_reg(`TCF_ADDR_JUDGE); `CHK(d, 4'h0)
      rd_reg(`TCF_ADDR_MODE); `CHK(d, `TCF_MODE_RST)
      rd_reg(7'h20); `CHK(d, 4'h0)
   endtask
   task t_sel;
      logic [1:0] s;
      for (int i = 0; i < 4; i++) begin
         s = i[1:0];
         wr_reg(`TCF_ADDR_MODE, {~s, s}); `CHK(int_sel, ~s)
         rd_reg(`TCF_ADDR_MODE); `CHK(d, {~s, s})
         rd_reg(`TCF_ADDR_JUDGE); wait_flag;
         rd_reg(`TCF_ADDR_JUDGE); `CHK(d, 4'h1)
         wait_flag; `CHK(n + 2, 4 * hv[i])
         if (hv[i] > 2) begin
            rd_reg(`TCF_ADDR_JUDGE); wr_reg(`TCF_ADDR_JUDGE, 4'hf);
            `CHK(flag, 1'b0)
            rd_reg(`TCF_ADDR_MODE); `CHK(d, {~s, s})
         end
      end
   endtask
   task t_ce;
      rd_reg(`TCF_ADDR_JUDGE);
      wait_flag;
      ce_pin = 1;
      repeat (4 * hv[3] - 2) @(negedge clock);
      // read lands on the sync rise
      rd_reg(`TCF_ADDR_JUDGE); `CHK(d, 4'h1)
      `CHK(ce_restart, 1'b0)
      `CHK(flag, 1'b1)
      n = 0;
      while (ce_restart !== 1'b1 && n < 60) begin @(negedge clock); n++; end
      `CHK(n, 4 * hv[3])
      `CHK(ce_restart, 1'b1)
      `CHK(flag, 1'b1)
      @(negedge clock); `CHK(ce_restart, 1'b0)
      ce_pin = 0;
   endtask
   task t_por;
      @(negedge clock); rst_n = 0;
      repeat (4) @(negedge clock);
      rst_n = 1;
      repeat (30) @(negedge clock);
      `CHK(flag, 1'b0)
      `CHK(int_sel, 2'h0)
      ce_pin = 1; n = 0;
      while (ce_restart !== 1'b1 && n < 60) begin @(negedge clock); n++; end
      `CHK(ce_restart, 1'b1)
      `CHK(flag, 1'b1)
      rd_reg(`TCF_ADDR_JUDGE); `CHK(d, 4'h1)
      ce_pin = 0;
   endtask
   task report_and_stop;
      $display("compares %0d errors %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Timeout guard
   always @(posedge clock) begin cyc++; if (cyc == 5000) begin failures++; report_and_stop; end end
   // Main sequence
   initial begin
      repeat (4) @(negedge clock);
      rst_n = 1;
      t_lock; t_sel; t_ce; t_por;
      report_and_stop;
   end
endmodule // tcf_timer_carry_tb_top
`default_nettype wire
